// ### design/dcc_pkg.sv
// Overview of operation
// - Local commands need local permission input
// - Remote commands need remote permission input
// - Open executes only with open permit
// - Close executes only with close permit
// - Operation block suppresses all switching
// - Two raw position inputs give position
// - Accepted commands become pulses; rejected: none
// - Three control models, direct normal after reset
// - Forced check stops client bypass, default on
// - Enhanced models: timeout flags invalid position
// - Pulse length 100 to 60000 ms
// - Early pulse end, never under 1000 ms
// - Intermediate reported only after intermediate time
// - Select-before-operate timeout cancels the command
// - Position code: intermediate, off, on, bad
// - 150 ms operation pulse, counts activations
// - Event on every position code change
package dcc_pkg;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int PS_PER_MS = 1000000000;
  localparam int MS_CYCLES_DEF = PS_PER_MS / CLK_PERIOD_PS;

  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_CMD = 6'h04;
  localparam logic [5:0] OFF_PULSE = 6'h08;
  localparam logic [5:0] OFF_MAXOP = 6'h0c;
  localparam logic [5:0] OFF_INTER = 6'h10;
  localparam logic [5:0] OFF_SBO = 6'h14;
  localparam logic [5:0] OFF_STATUS = 6'h18;
  localparam logic [5:0] OFF_OPCNT = 6'h1c;
  localparam logic [5:0] OFF_IRQ_STAT = 6'h20;
  localparam logic [5:0] OFF_IRQ_CLR = 6'h24;
  localparam logic [5:0] OFF_IRQ_EN = 6'h28;

  localparam int CTRL_FORCED = 2;
  localparam int CTRL_CNT_CLR = 3;
  localparam int CMD_W = 5;
  localparam int N_EV = 5;
  localparam int EV_STATUS = 0;
  localparam int EV_INVALID = 1;
  localparam int EV_INTERM = 2;

  localparam logic [15:0] PULSE_MIN = 16'h0064;
  localparam logic [15:0] MAXOP_MIN = 16'h000a;
  localparam logic [15:0] INTER_MIN = 16'h0014;
  localparam logic [15:0] SBO_MIN = 16'h03e8;
  localparam logic [15:0] SBO_MAX = 16'h4e20;
  localparam logic [15:0] MS_MAX = 16'hea60;
  localparam logic [15:0] RST_PULSE = 16'h03e8;
  localparam logic [15:0] RST_MAXOP = 16'h2710;
  localparam logic [15:0] RST_INTER = 16'h2710;
  localparam logic [15:0] RST_SBO = 16'h1388;
  localparam logic [15:0] MIN_PULSE_MS = 16'h03e8;
  localparam logic [15:0] OPER_PULSE_MS = 16'h0096;

  localparam logic [1:0] POS_INTER = 2'h0;
  localparam logic [1:0] POS_OFF = 2'h1;
  localparam logic [1:0] POS_ON = 2'h2;
  localparam logic [1:0] POS_BAD = 2'h3;

  typedef enum logic [1:0] {MDL_DIRECT_NORMAL, MDL_DIRECT_ENH, MDL_SBO_ENH} dcc_model_t;
  typedef enum logic {ST_IDLE, ST_PULSE} dcc_state_t;

  typedef struct packed {
    logic check;
    logic remote;
    logic select;
    logic close;
    logic open;
  } dcc_cmd_t;

  typedef struct packed {
    logic local_permit;
    logic remote_permit;
    logic open_permit;
    logic close_permit;
    logic operation_block;
    logic opened;
    logic closed;
  } dcc_pins_t;
endpackage

// ### design/dcc_sync.sv
`timescale 1ns/10ps
`default_nettype none
module dcc_sync #(
  parameter int W = 1
)(
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  if (W < 1) begin : g_chk
    $error("dcc_sync width must be at least 1");
  end

  // A bit follows only once stages two and three agree
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q <= '0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q <= (s2 & s3) | (q & (s2 ^ s3));
    end
  end
endmodule
`default_nettype wire

// ### design/dcc_disconnector_ctrl.sv
// The register offsets and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module dcc_disconnector_ctrl
  import dcc_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF
)(
  input wire logic clk,
  input wire logic reset,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic local_permit,
  input wire logic remote_permit,
  input wire logic open_permit,
  input wire logic close_permit,
  input wire logic operation_block,
  input wire logic position_opened_in,
  input wire logic position_closed_in,
  output logic open_pulse_out,
  output logic close_pulse_out,
  output logic operation_pulse_out,
  output logic [1:0] position_status_code,
  output logic opened_out,
  output logic closed_out,
  output logic irq
);
  localparam int TW = $clog2(MS_CYCLES);

  if (MS_CYCLES < 2) begin : g_chk
    $error("MS_CYCLES must be at least 2");
  end

  function automatic logic [15:0] merge16(input logic [15:0] o, input logic [31:0] n,
                                          input logic [3:0] be);
    merge16 = {be[1] ? n[15:8] : o[15:8], be[0] ? n[7:0] : o[7:0]};
  endfunction

  function automatic logic fits(input logic [15:0] v, input logic [15:0] lo,
                                input logic [15:0] hi);
    fits = (v >= lo) && (v <= hi);
  endfunction

  dcc_pins_t raw;
  dcc_pins_t pin;
  assign raw = {local_permit, remote_permit, open_permit, close_permit,
                operation_block, position_opened_in, position_closed_in};

  dcc_sync #(.W($bits(dcc_pins_t))) u_sync (
    .clk(clk),
    .reset(reset),
    .d(raw),
    .q(pin)
  );

  // Millisecond tick
  logic [TW-1:0] tick_cnt;
  logic tick;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else if (tick_cnt == TW'(MS_CYCLES - 1)) begin
      tick_cnt <= '0;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      tick <= 1'b0;
    end
  end

  // Bus slave: one wait state per access
  logic acc_wr;
  logic [31:0] rdata;
  assign acc_wr = avs_write & ~avs_waitrequest;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if (avs_read & avs_waitrequest) begin
        avs_readdata <= rdata;
      end
    end
  end

  // Settings
  dcc_model_t model;
  logic forced;
  logic [15:0] pulse_len;
  logic [15:0] maxop_len;
  logic [15:0] inter_len;
  logic [15:0] sbo_len;
  logic [N_EV-1:0] irq_en;
  logic [15:0] w_pulse;
  logic [15:0] w_maxop;
  logic [15:0] w_inter;
  logic [15:0] w_sbo;
  assign w_pulse = merge16(pulse_len, avs_writedata, avs_byteenable);
  assign w_maxop = merge16(maxop_len, avs_writedata, avs_byteenable);
  assign w_inter = merge16(inter_len, avs_writedata, avs_byteenable);
  assign w_sbo = merge16(sbo_len, avs_writedata, avs_byteenable);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      model <= MDL_DIRECT_NORMAL;
      forced <= 1'b1;
      pulse_len <= RST_PULSE;
      maxop_len <= RST_MAXOP;
      inter_len <= RST_INTER;
      sbo_len <= RST_SBO;
      irq_en <= '0;
    end else if (acc_wr) begin
      case (avs_address)
        OFF_CTRL: if (avs_byteenable[0]) begin
          if (avs_writedata[1:0] != 2'h3) begin
            model <= dcc_model_t'(avs_writedata[1:0]);
          end
          forced <= avs_writedata[CTRL_FORCED];
        end
        OFF_PULSE: if (fits(w_pulse, PULSE_MIN, MS_MAX)) pulse_len <= w_pulse;
        OFF_MAXOP: if (fits(w_maxop, MAXOP_MIN, MS_MAX)) maxop_len <= w_maxop;
        OFF_INTER: if (fits(w_inter, INTER_MIN, MS_MAX)) inter_len <= w_inter;
        OFF_SBO: if (fits(w_sbo, SBO_MIN, SBO_MAX)) sbo_len <= w_sbo;
        OFF_IRQ_EN: if (avs_byteenable[0]) irq_en <= avs_writedata[N_EV-1:0];
        default: ;
      endcase
    end
  end

  // Command checks
  dcc_cmd_t cmd;
  dcc_state_t state;
  logic selected;
  logic cmd_wr;
  logic src_ok;
  logic bypass;
  logic lock_ok;
  logic go;
  logic do_select;
  logic refused;
  logic operate;
  assign cmd = dcc_cmd_t'(avs_writedata[CMD_W-1:0]);
  assign cmd_wr = acc_wr && avs_address == OFF_CMD && avs_byteenable[0];
  assign operate = cmd_wr && (cmd.open || cmd.close);
  assign src_ok = cmd.remote ? pin.remote_permit : pin.local_permit;
  assign bypass = cmd.remote && !forced && !cmd.check;
  assign lock_ok = bypass || (cmd.open ? pin.open_permit : pin.close_permit);
  assign go = operate && (cmd.open ^ cmd.close) && src_ok && lock_ok && !pin.operation_block
              && (model != MDL_SBO_ENH || selected) && state == ST_IDLE;
  assign do_select = cmd_wr && cmd.select && !(cmd.open || cmd.close) && model == MDL_SBO_ENH
                     && src_ok && !pin.operation_block;
  assign refused = (operate && !go) || (cmd_wr && cmd.select && !do_select);

  // Command pulse
  logic [15:0] pulse_ms;
  logic dir_close;
  logic reached;
  logic pulse_end;
  assign reached = dir_close ? (pin.closed && !pin.opened) : (pin.opened && !pin.closed);
  assign pulse_end = pulse_ms >= pulse_len || (reached && pulse_ms >= MIN_PULSE_MS);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= ST_IDLE;
      pulse_ms <= 16'h0;
      dir_close <= 1'b0;
      open_pulse_out <= 1'b0;
      close_pulse_out <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: if (go) begin
          state <= ST_PULSE;
          pulse_ms <= 16'h0;
          dir_close <= cmd.close;
          open_pulse_out <= cmd.open;
          close_pulse_out <= cmd.close;
        end
        ST_PULSE: if (pulse_end) begin
          state <= ST_IDLE;
          open_pulse_out <= 1'b0;
          close_pulse_out <= 1'b0;
        end else if (tick) begin
          pulse_ms <= pulse_ms + 16'h1;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Operating time watch in enhanced models
  logic watch;
  logic [15:0] watch_ms;
  logic ev_invalid;
  assign ev_invalid = watch && !go && !reached && watch_ms >= maxop_len;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      watch <= 1'b0;
      watch_ms <= 16'h0;
    end else if (go) begin
      watch <= model != MDL_DIRECT_NORMAL;
      watch_ms <= 16'h0;
    end else if (watch) begin
      if (reached || ev_invalid) begin
        watch <= 1'b0;
      end else if (tick) begin
        watch_ms <= watch_ms + 16'h1;
      end
    end
  end

  // Select before operate
  logic [15:0] sbo_ms;
  logic ev_sbo;
  assign ev_sbo = selected && !do_select && !operate && sbo_ms >= sbo_len;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      selected <= 1'b0;
      sbo_ms <= 16'h0;
    end else if (do_select) begin
      selected <= 1'b1;
      sbo_ms <= 16'h0;
    end else if (selected) begin
      if (operate || ev_sbo || model != MDL_SBO_ENH) begin
        selected <= 1'b0;
      end else if (tick) begin
        sbo_ms <= sbo_ms + 16'h1;
      end
    end
  end

  // Position reporting
  logic [1:0] raw_code;
  logic [1:0] next_code;
  logic [1:0] last_pos;
  logic [15:0] inter_ms;
  logic ev_status;
  logic ev_interm;
  logic oper_trig;
  assign raw_code = {pin.closed, pin.opened};
  assign next_code = (raw_code != POS_INTER) ? raw_code :
                     (inter_ms >= inter_len) ? POS_INTER : position_status_code;
  assign ev_status = next_code != position_status_code;
  assign ev_interm = ev_status && next_code == POS_INTER;
  assign oper_trig = (next_code == POS_OFF || next_code == POS_ON) && last_pos != POS_INTER
                     && next_code != last_pos;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      position_status_code <= POS_INTER;
      opened_out <= 1'b0;
      closed_out <= 1'b0;
      last_pos <= POS_INTER;
      inter_ms <= 16'h0;
    end else begin
      position_status_code <= next_code;
      opened_out <= next_code == POS_OFF;
      closed_out <= next_code == POS_ON;
      if (next_code == POS_OFF || next_code == POS_ON) begin
        last_pos <= next_code;
      end
      if (raw_code != POS_INTER) begin
        inter_ms <= 16'h0;
      end else if (tick && inter_ms < inter_len) begin
        inter_ms <= inter_ms + 16'h1;
      end
    end
  end

  // Operation pulse and counter
  logic [15:0] oper_ms;
  logic [31:0] op_count;
  logic cnt_clr;
  assign cnt_clr = acc_wr && avs_address == OFF_CTRL && avs_byteenable[0]
                   && avs_writedata[CTRL_CNT_CLR];
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      operation_pulse_out <= 1'b0;
      oper_ms <= 16'h0;
    end else if (oper_trig) begin
      operation_pulse_out <= 1'b1;
      oper_ms <= 16'h0;
    end else if (operation_pulse_out) begin
      if (oper_ms >= OPER_PULSE_MS) begin
        operation_pulse_out <= 1'b0;
      end else if (tick) begin
        oper_ms <= oper_ms + 16'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      op_count <= 32'h0;
    end else begin
      op_count <= (cnt_clr ? 32'h0 : op_count)
                  + {31'h0, oper_trig && !operation_pulse_out};
    end
  end

  // Interrupt status
  logic [N_EV-1:0] ev;
  logic [N_EV-1:0] irq_stat;
  logic [N_EV-1:0] irq_clr;
  assign ev = {ev_sbo, refused, ev_interm, ev_invalid, ev_status};
  assign irq_clr = (acc_wr && avs_address == OFF_IRQ_CLR && avs_byteenable[0]) ?
                   avs_writedata[N_EV-1:0] : '0;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_stat <= '0;
      irq <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | ev;
      irq <= |(irq_stat & irq_en);
    end
  end

  always_comb begin
    case (avs_address)
      OFF_CTRL: rdata = {29'h0, forced, model};
      OFF_PULSE: rdata = {16'h0, pulse_len};
      OFF_MAXOP: rdata = {16'h0, maxop_len};
      OFF_INTER: rdata = {16'h0, inter_len};
      OFF_SBO: rdata = {16'h0, sbo_len};
      OFF_STATUS: rdata = {27'h0, selected, watch, state == ST_PULSE, position_status_code};
      OFF_OPCNT: rdata = op_count;
      OFF_IRQ_STAT: rdata = 32'(irq_stat);
      OFF_IRQ_EN: rdata = 32'(irq_en);
      default: rdata = 32'h0;
    endcase
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_no_start;
    !($rose(open_pulse_out) || $rose(close_pulse_out));
  endsequence

  sequence s_oper_hold;
    operation_pulse_out [*8];
  endsequence

  a_no_overlap: assert property (!(open_pulse_out && close_pulse_out))
    else $error("open and close pulses overlap");
  a_local_perm: assert property (cmd_wr && !cmd.remote && !pin.local_permit |=> s_no_start)
    else $error("local command ran without local permission");
  a_remote_perm: assert property (cmd_wr && cmd.remote && !pin.remote_permit |=> s_no_start)
    else $error("remote command ran without remote permission");
  a_open_lock: assert property (cmd_wr && forced && cmd.open && !pin.open_permit
                                |=> s_no_start)
    else $error("open ran without open permit");
  a_close_lock: assert property (cmd_wr && !bypass && cmd.close && !pin.close_permit
                                 |=> s_no_start)
    else $error("close ran without close permit");
  a_block_op: assert property (cmd_wr && pin.operation_block |=> s_no_start)
    else $error("command ran while blocked");
  a_fwd_cmd: assert property (go |=> open_pulse_out == $past(cmd.open)
                              && close_pulse_out == $past(cmd.close))
    else $error("accepted command not forwarded");
  a_pulse_len: assert property (state == ST_PULSE && pulse_ms >= pulse_len
                                |=> state == ST_IDLE && !open_pulse_out)
    else $error("pulse outlived its length");
  a_min_pulse: assert property ($fell(open_pulse_out) || $fell(close_pulse_out)
                                |-> pulse_ms >= pulse_len || pulse_ms >= MIN_PULSE_MS)
    else $error("pulse ended too early");
  a_op_timeout: assert property (ev_invalid |=> irq_stat[EV_INVALID] && !watch)
    else $error("operating timeout not reported");
  a_interm_ev: assert property (ev_interm |=> irq_stat[EV_INTERM])
    else $error("intermediate state not reported");
  a_sbo_need: assert property (cmd_wr && model == MDL_SBO_ENH && !selected
                               |=> s_no_start)
    else $error("operate ran without selection");
  a_interm_wait: assert property (position_status_code == POS_INTER
                                  && $past(position_status_code) != POS_INTER
                                  |-> $past(inter_ms) >= $past(inter_len))
    else $error("intermediate reported early");
  a_code_map: assert property (position_status_code == POS_ON
                               |-> closed_out && !opened_out)
    else $error("position code and outputs disagree");
  a_status_ev: assert property (position_status_code != $past(position_status_code)
                                |-> irq_stat[EV_STATUS])
    else $error("status change without event");
  a_oper_cnt: assert property ($rose(operation_pulse_out) && !$past(cnt_clr)
                               |-> op_count == $past(op_count) + 32'h1 ##1 s_oper_hold)
    else $error("operation pulse or counter wrong");
endmodule
`default_nettype wire

// ### verif/dcc_switch_model.sv
`timescale 1ns/10ps
`default_nettype none
module dcc_switch_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic open_cmd,
  input wire logic close_cmd,
  input wire logic stuck,
  input wire logic both_on,
  input wire logic [15:0] travel,
  output logic opened,
  output logic closed
);
  logic at_closed;
  logic moving;
  logic [15:0] left;

  // Contacts leave on a coil pulse and land after the travel time
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      at_closed <= 1'b0;
      moving <= 1'b0;
      left <= 16'h0000;
    end else if (!moving && !stuck && ((open_cmd && at_closed) || (close_cmd && !at_closed))) begin
      moving <= 1'b1;
      left <= travel;
    end else if (moving) begin
      if (left == 16'h0000) begin
        moving <= 1'b0;
        at_closed <= !at_closed;
      end else begin
        left <= left - 16'h0001;
      end
    end
  end

  // Both contacts low while travelling, unless both_on drives both high
  assign opened = both_on | (!moving & !at_closed);
  assign closed = both_on | (!moving & at_closed);
endmodule
`default_nettype wire

// ### verif/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import dcc_pkg::*;
  localparam int MS = 4;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  dcc_pins_t pins = 7'h78;
  logic stuck = 1'b0;
  logic both_on = 1'b0;
  logic [15:0] travel = 16'h00c8;
  logic opened_in, closed_in, open_pulse_out, close_pulse_out, operation_pulse_out;
  logic opened_out, closed_out, irq;
  logic [1:0] position_status_code;
  logic [31:0] q;
  int num_errors = 0, checks_done = 0, cyc = 0, opw = 0, op_last = 0, w = 0, exp_cnt = 0;
  dcc_pins_t rp [5] = '{7'h38, 7'h58, 7'h68, 7'h70, 7'h7c};
  logic [4:0] rc [5] = '{5'h02, 5'h0a, 5'h01, 5'h02, 5'h02};

  dcc_disconnector_ctrl #(.MS_CYCLES(MS)) uut (.clk(clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .local_permit(pins.local_permit), .remote_permit(pins.remote_permit),
    .open_permit(pins.open_permit), .close_permit(pins.close_permit),
    .operation_block(pins.operation_block), .position_opened_in(opened_in),
    .position_closed_in(closed_in), .open_pulse_out(open_pulse_out),
    .close_pulse_out(close_pulse_out), .operation_pulse_out(operation_pulse_out),
    .position_status_code(position_status_code), .opened_out(opened_out),
    .closed_out(closed_out), .irq(irq));
  dcc_switch_model sw (.clk(clk), .reset(reset), .open_cmd(open_pulse_out),
    .close_cmd(close_pulse_out), .stuck(stuck), .both_on(both_on), .travel(travel),
    .opened(opened_in), .closed(closed_in));

  initial begin
    forever #2 clk = ~clk;
  end

  // Cycle count, operation pulse width and watchdog
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (operation_pulse_out) begin
      opw <= opw + 1;
    end else if (opw != 0) begin
      op_last <= opw;
      opw <= 0;
    end
    if (cyc > 40000) begin
      num_errors++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cmd(input logic [4:0] v);
    wr(OFF_CMD, {27'h0, v});
    tick(1);
  endtask
  task automatic inr(input int v, input int n);
    chk({31'h0, v >= (n - 2) * MS && v <= (n + 1) * MS + 8}, 32'h1);
  endtask
  task automatic wait_fall();
    int t0;
    t0 = cyc;
    while (open_pulse_out | close_pulse_out) @(posedge clk);
    w = cyc - t0;
  endtask
  task automatic endt(input int n);
    $display("test %0d done", n);
  endtask

  initial begin
    void'($urandom(32'hc0dd));
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    tick(12);
    rd(OFF_CTRL, 32'hf, 32'h4);
    rd(OFF_PULSE, 32'hffff, 32'h3e8);
    rd(OFF_MAXOP, 32'hffff, 32'h2710);
    rd(OFF_INTER, 32'hffff, 32'h2710);
    rd(OFF_SBO, 32'hffff, 32'h1388);
    rd(6'h2c, 32'hffffffff, 32'h0);
    rd(OFF_STATUS, 32'h3, {30'h0, POS_OFF});
    chk(opened_out, 1'b1);
    w = 100 + $urandom_range(59900);
    wr(OFF_PULSE, w);
    rd(OFF_PULSE, 32'hffff, w);
    wr(OFF_PULSE, 32'd99);
    rd(OFF_PULSE, 32'hffff, w);
    avs_byteenable <= 4'h0;
    wr(OFF_PULSE, 32'd1500);
    avs_byteenable <= 4'hf;
    rd(OFF_PULSE, 32'hffff, w);
    wr(OFF_PULSE, 32'd1500);
    endt(0);
    for (int i = 0; i < 5; i++) begin
      wr(OFF_IRQ_CLR, 32'h1f);
      @(posedge clk);
      pins <= rp[i];
      tick(8);
      cmd(rc[i]);
      tick(2);
      chk({open_pulse_out, close_pulse_out}, 2'b00);
      rd(OFF_IRQ_STAT, 32'h8, 32'h8);
    end
    @(posedge clk);
    pins <= 7'h78;
    tick(8);
    endt(1);
    wr(OFF_IRQ_CLR, 32'h1f);
    cmd(5'h02);
    chk(close_pulse_out, 1'b1);
    cmd(5'h01);
    tick(1);
    chk({open_pulse_out, close_pulse_out}, 2'b01);
    wait_fall();
    inr(w, 1000);
    exp_cnt++;
    inr(op_last, 150);
    rd(OFF_STATUS, 32'h3, {30'h0, POS_ON});
    chk(closed_out, 1'b1);
    chk(position_status_code, POS_ON);
    rd(OFF_OPCNT, 32'hffffffff, exp_cnt);
    rd(OFF_IRQ_STAT, 32'h9, 32'h9);
    endt(2);
    wr(OFF_CTRL, 32'h5);
    wr(OFF_MAXOP, 32'd10);
    wr(OFF_INTER, 32'd20);
    wr(OFF_PULSE, 32'd100);
    travel <= 16'd800;
    wr(OFF_IRQ_CLR, 32'h1f);
    cmd(5'h01);
    chk(open_pulse_out, 1'b1);
    tick(15 * MS);
    rd(OFF_STATUS, 32'h3, {30'h0, POS_ON});
    tick(15 * MS);
    rd(OFF_STATUS, 32'h3, {30'h0, POS_INTER});
    rd(OFF_IRQ_STAT, 32'h6, 32'h6);
    tick(800);
    exp_cnt++;
    rd(OFF_STATUS, 32'h3, {30'h0, POS_OFF});
    rd(OFF_OPCNT, 32'hffffffff, exp_cnt);
    endt(3);
    wr(OFF_CTRL, 32'h6);
    wr(OFF_SBO, 32'd1000);
    travel <= 16'd200;
    cmd(5'h02);
    tick(2);
    chk(close_pulse_out, 1'b0);
    wr(OFF_CMD, 32'h4);
    tick(1000 * MS + 20);
    rd(OFF_IRQ_STAT, 32'h10, 32'h10);
    cmd(5'h02);
    tick(2);
    chk(close_pulse_out, 1'b0);
    wr(OFF_CMD, 32'h4);
    tick(10);
    cmd(5'h02);
    chk(close_pulse_out, 1'b1);
    wait_fall();
    tick(700);
    exp_cnt++;
    endt(4);
    wr(OFF_CTRL, 32'h4);
    @(posedge clk);
    pins <= 7'h68;
    tick(8);
    cmd(5'h09);
    tick(2);
    chk(open_pulse_out, 1'b0);
    wr(OFF_CTRL, 32'h0);
    cmd(5'h09);
    chk(open_pulse_out, 1'b1);
    wait_fall();
    inr(w, 100);
    tick(700);
    exp_cnt++;
    inr(op_last, 150);
    rd(OFF_OPCNT, 32'hffffffff, exp_cnt);
    wr(OFF_CTRL, 32'h1);
    wr(OFF_IRQ_CLR, 32'h1f);
    stuck <= 1'b1;
    cmd(5'h02);
    chk(close_pulse_out, 1'b1);
    wait_fall();
    stuck <= 1'b0;
    inr(w, 100);
    rd(OFF_IRQ_STAT, 32'h6, 32'h2);
    rd(OFF_STATUS, 32'h3, {30'h0, POS_OFF});
    endt(5);
    wr(OFF_IRQ_EN, 32'h1);
    wr(OFF_IRQ_CLR, 32'h1f);
    tick(2);
    chk(irq, 1'b0);
    @(posedge clk);
    both_on <= 1'b1;
    tick(12);
    rd(OFF_STATUS, 32'h3, {30'h0, POS_BAD});
    chk(irq, 1'b1);
    wr(OFF_IRQ_CLR, 32'h1);
    tick(2);
    chk(irq, 1'b0);
    wr(OFF_IRQ_EN, 32'h0);
    both_on <= 1'b0;
    tick(12);
    chk(irq, 1'b0);
    rd(OFF_IRQ_STAT, 32'h1, 32'h1);
    rd(OFF_OPCNT, 32'hffffffff, exp_cnt);
    wr(OFF_CTRL, 32'h7);
    rd(OFF_CTRL, 32'hf, 32'h5);
    wr(OFF_CTRL, 32'hc);
    rd(OFF_OPCNT, 32'hffffffff, 32'h0);
    endt(6);
    results();
  end
endmodule
`default_nettype wire
